// ==== verilog/dppa_defs.svh ====
// constants for the dual parallel port adapter
`ifndef DPPA_DEFS_SVH
`define DPPA_DEFS_SVH

// host register addresses on {reg_sel_high, reg_sel_low}
`define DPPA_ADDR_PORT_A 2'h0
`define DPPA_ADDR_CTRL_A 2'h1
`define DPPA_ADDR_PORT_B 2'h2
`define DPPA_ADDR_CTRL_B 2'h3

// address bit that picks control over port, and bit that picks side b
`define DPPA_ADDR_CTRL_BIT 0
`define DPPA_ADDR_SIDE_BIT 1

// side indices and count
`define DPPA_SIDE_A 0
`define DPPA_SIDE_B 1
`define DPPA_SIDES 2

// reset values
`define DPPA_BYTE_RESET 8'h00
`define DPPA_BIT_RESET 1'h0
`define DPPA_ADDR_RESET 2'h0

// widths of the synchronised bundles
`define DPPA_HOST_W 15
`define DPPA_PIN_W 20

`endif

// ==== verilog/dppa_pkg.sv ====
// types shared by the dual parallel port adapter
`default_nettype none
package dppa_pkg;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic flag_first;   // bit 7, set by the first control input
    logic flag_second;  // bit 6, set by the second control line
    logic sec_out_mode; // bit 5, second line is an output when 1
    logic sec_edge;     // bit 4, 1 = rising edge, or output level in output mode
    logic sec_en;       // bit 3, interrupt enable of the second line
    logic port_sel;     // bit 2, 1 = out latch / pins, 0 = line mode
    logic first_edge;   // bit 1, 1 = rising edge active
    logic first_en;     // bit 0, interrupt enable of the first input
  } dppa_ctl_t;

  // host bus pins as sampled together
  typedef struct packed {
    logic phi2;
    logic read_not_write;
    logic [1:0] addr;
    logic cs_high0;
    logic cs_high1;
    logic cs_low_n;
    logic [7:0] data;
  } dppa_host_t;

endpackage : dppa_pkg
`default_nettype wire

// ==== verilog/dppa_top.sv ====
// dual parallel port adapter: host register bus, two port sections, edge flags
`include "dppa_defs.svh"
`default_nettype none

// three-stage input synchroniser, new value taken once stages two and three agree
module dppa_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  // a value only counts once it has held for two samples
  always_comb begin
    q_next = (s2_reg == s3_reg) ? s3_reg : q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= q_next;
    end
  end
endmodule : dppa_sync

module dppa_top
  import dppa_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host bus
  input wire logic phi2,
  input wire logic read_not_write,
  input wire logic reg_sel_low,
  input wire logic reg_sel_high,
  input wire logic cs_high0,
  input wire logic cs_high1,
  input wire logic cs_low_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  // open-drain interrupt requests
  output logic side_a_int_req_n_out,
  output logic side_a_int_req_n_oe,
  output logic side_b_int_req_n_out,
  output logic side_b_int_req_n_oe,
  // side a peripheral lines
  input wire logic [7:0] side_a_port_lines_in,
  output logic [7:0] side_a_port_lines_out,
  output logic [7:0] side_a_port_lines_oe,
  input wire logic side_a_ctl_in_first,
  input wire logic side_a_ctl_line_second_in,
  output logic side_a_ctl_line_second_out,
  output logic side_a_ctl_line_second_oe,
  // side b peripheral lines
  input wire logic [7:0] side_b_port_lines_in,
  output logic [7:0] side_b_port_lines_out,
  output logic [7:0] side_b_port_lines_oe,
  input wire logic side_b_ctl_in_first,
  input wire logic side_b_ctl_line_second_in,
  output logic side_b_ctl_line_second_out,
  output logic side_b_ctl_line_second_oe
);
  logic rst_s1_reg;
  logic rst_n;
  dppa_host_t host;
  logic [`DPPA_PIN_W-1:0] pin_q;
  logic [7:0] port_in [`DPPA_SIDES];
  logic ctl1_in [`DPPA_SIDES];
  logic ctl2_in [`DPPA_SIDES];

  dppa_ctl_t ctl_reg [`DPPA_SIDES];
  dppa_ctl_t ctl_next [`DPPA_SIDES];
  logic [7:0] mode_reg [`DPPA_SIDES];
  logic [7:0] mode_next [`DPPA_SIDES];
  logic [7:0] latch_reg [`DPPA_SIDES];
  logic [7:0] latch_next [`DPPA_SIDES];
  logic prev1_reg [`DPPA_SIDES];
  logic prev2_reg [`DPPA_SIDES];
  logic set1 [`DPPA_SIDES];
  logic set2 [`DPPA_SIDES];
  logic clr [`DPPA_SIDES];

  logic [7:0] hold_data_reg;
  logic [7:0] hold_data_next;
  logic [1:0] hold_addr_reg;
  logic [1:0] hold_addr_next;
  logic hold_write_reg;
  logic hold_write_next;
  logic hold_sel_reg;
  logic hold_sel_next;
  logic prev_phi2_reg;
  logic [7:0] dout_next;
  logic chip_sel;
  logic phi2_fall;
  logic commit;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= `DPPA_BIT_RESET;
      rst_n <= `DPPA_BIT_RESET;
    end else begin
      rst_s1_reg <= 1'h1;
      rst_n <= rst_s1_reg;
    end
  end

  // host pins come from the processor's timing, so they are synchronised as one bundle
  dppa_sync #(.W(`DPPA_HOST_W)) u_host_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({phi2, read_not_write, reg_sel_high, reg_sel_low, cs_high0, cs_high1, cs_low_n,
        host_data_in}),
    .q(host)
  );

  // peripheral pins
  dppa_sync #(.W(`DPPA_PIN_W)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({side_a_port_lines_in, side_b_port_lines_in, side_a_ctl_in_first,
        side_a_ctl_line_second_in, side_b_ctl_in_first, side_b_ctl_line_second_in}),
    .q(pin_q)
  );

  // unpack synchronised pins per side
  assign port_in[`DPPA_SIDE_A] = pin_q[19:12];
  assign port_in[`DPPA_SIDE_B] = pin_q[11:4];
  assign ctl1_in[`DPPA_SIDE_A] = pin_q[3];
  assign ctl2_in[`DPPA_SIDE_A] = pin_q[2];
  assign ctl1_in[`DPPA_SIDE_B] = pin_q[1];
  assign ctl2_in[`DPPA_SIDE_B] = pin_q[0];

  // chip selected and end of the phase-2 pulse
  assign chip_sel = host.cs_high0 & host.cs_high1 & ~host.cs_low_n;
  assign phi2_fall = prev_phi2_reg & ~host.phi2;
  assign commit = phi2_fall & hold_sel_reg;

  // write holding: the bus value is tracked for the whole high phase
  always_comb begin
    hold_data_next = hold_data_reg;
    hold_addr_next = hold_addr_reg;
    hold_write_next = hold_write_reg;
    hold_sel_next = hold_sel_reg;
    if (host.phi2) begin
      hold_data_next = host.data;
      hold_addr_next = host.addr;
      hold_write_next = ~host.read_not_write;
      hold_sel_next = chip_sel;
    end else if (phi2_fall) begin
      hold_sel_next = `DPPA_BIT_RESET; // one commit per pulse
    end
  end

  // register file and edge logic, one pass per section
  always_comb begin
    for (int s = 0; s < `DPPA_SIDES; s++) begin
      ctl_next[s] = ctl_reg[s];
      mode_next[s] = mode_reg[s];
      latch_next[s] = latch_reg[s];
      // active edge chosen by the control bits
      set1[s] = ctl_reg[s].first_edge ? (ctl1_in[s] & ~prev1_reg[s]) :
                (~ctl1_in[s] & prev1_reg[s]);
      set2[s] = ~ctl_reg[s].sec_out_mode & (ctl_reg[s].sec_edge ?
                (ctl2_in[s] & ~prev2_reg[s]) : (~ctl2_in[s] & prev2_reg[s]));
      clr[s] = commit & ~hold_write_reg & (hold_addr_reg[`DPPA_ADDR_SIDE_BIT] == s[0]) &
               ~hold_addr_reg[`DPPA_ADDR_CTRL_BIT] & ctl_reg[s].port_sel;
      if (commit & hold_write_reg & (hold_addr_reg[`DPPA_ADDR_SIDE_BIT] == s[0])) begin
        if (hold_addr_reg[`DPPA_ADDR_CTRL_BIT]) begin
          // flags keep their state, only bits 5..0 are written
          ctl_next[s] = dppa_ctl_t'({ctl_reg[s].flag_first, ctl_reg[s].flag_second,
                                     hold_data_reg[5:0]});
        end else if (ctl_reg[s].port_sel) begin
          latch_next[s] = hold_data_reg;
        end else begin
          mode_next[s] = hold_data_reg;
        end
      end
      // a new edge in the clearing cycle is kept
      ctl_next[s].flag_first = set1[s] | (ctl_reg[s].flag_first & ~clr[s]);
      ctl_next[s].flag_second = set2[s] | (ctl_reg[s].flag_second & ~clr[s]);
    end
  end

  // read data, registered every cycle from the current address
  always_comb begin
    dout_next = ctl_reg[host.addr[`DPPA_ADDR_SIDE_BIT]];
    if (!host.addr[`DPPA_ADDR_CTRL_BIT]) begin
      dout_next = ctl_reg[host.addr[`DPPA_ADDR_SIDE_BIT]].port_sel ?
                  port_in[host.addr[`DPPA_ADDR_SIDE_BIT]] :
                  mode_reg[host.addr[`DPPA_ADDR_SIDE_BIT]];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < `DPPA_SIDES; s++) begin
        ctl_reg[s] <= dppa_ctl_t'(`DPPA_BYTE_RESET);
        mode_reg[s] <= `DPPA_BYTE_RESET;
        latch_reg[s] <= `DPPA_BYTE_RESET;
        prev1_reg[s] <= `DPPA_BIT_RESET;
        prev2_reg[s] <= `DPPA_BIT_RESET;
      end
      hold_data_reg <= `DPPA_BYTE_RESET;
      hold_addr_reg <= `DPPA_ADDR_RESET;
      hold_write_reg <= `DPPA_BIT_RESET;
      hold_sel_reg <= `DPPA_BIT_RESET;
      prev_phi2_reg <= `DPPA_BIT_RESET;
      host_data_out <= `DPPA_BYTE_RESET;
    end else begin
      for (int s = 0; s < `DPPA_SIDES; s++) begin
        ctl_reg[s] <= ctl_next[s];
        mode_reg[s] <= mode_next[s];
        latch_reg[s] <= latch_next[s];
        prev1_reg[s] <= ctl1_in[s];
        prev2_reg[s] <= ctl2_in[s];
      end
      hold_data_reg <= hold_data_next;
      hold_addr_reg <= hold_addr_next;
      hold_write_reg <= hold_write_next;
      hold_sel_reg <= hold_sel_next;
      prev_phi2_reg <= host.phi2;
      host_data_out <= dout_next;
    end
  end

  // bus driven only in the high phase of a selected read
  assign host_data_oe = host.phi2 & chip_sel & host.read_not_write;

  // port lines: line mode drives the enables, out latch the levels
  assign side_a_port_lines_out = latch_reg[`DPPA_SIDE_A];
  assign side_a_port_lines_oe = mode_reg[`DPPA_SIDE_A];
  assign side_b_port_lines_out = latch_reg[`DPPA_SIDE_B];
  assign side_b_port_lines_oe = mode_reg[`DPPA_SIDE_B];

  // second line as a plain output follows bit 4; handshake modes are not built
  assign side_a_ctl_line_second_out = ctl_reg[`DPPA_SIDE_A].sec_edge;
  assign side_a_ctl_line_second_oe = ctl_reg[`DPPA_SIDE_A].sec_out_mode;
  assign side_b_ctl_line_second_out = ctl_reg[`DPPA_SIDE_B].sec_edge;
  assign side_b_ctl_line_second_oe = ctl_reg[`DPPA_SIDE_B].sec_out_mode;

  // open drain: level is always low, enable pulls the wire
  assign side_a_int_req_n_out = `DPPA_BIT_RESET;
  assign side_b_int_req_n_out = `DPPA_BIT_RESET;
  assign side_a_int_req_n_oe =
    (ctl_reg[`DPPA_SIDE_A].flag_first & ctl_reg[`DPPA_SIDE_A].first_en) |
    (ctl_reg[`DPPA_SIDE_A].flag_second & ctl_reg[`DPPA_SIDE_A].sec_en &
     ~ctl_reg[`DPPA_SIDE_A].sec_out_mode);
  assign side_b_int_req_n_oe =
    (ctl_reg[`DPPA_SIDE_B].flag_first & ctl_reg[`DPPA_SIDE_B].first_en) |
    (ctl_reg[`DPPA_SIDE_B].flag_second & ctl_reg[`DPPA_SIDE_B].sec_en &
     ~ctl_reg[`DPPA_SIDE_B].sec_out_mode);

endmodule : dppa_top
`default_nettype wire

// ==== test/dppa_checker.sv ====
// port assertions for the dual parallel port adapter
`default_nettype none
module dppa_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host bus
  input wire logic phi2,
  input wire logic read_not_write,
  input wire logic cs_low_n,
  input wire logic host_data_oe,
  // side outputs
  input wire logic side_a_int_req_n_out,
  input wire logic side_b_int_req_n_out,
  input wire logic side_a_int_req_n_oe,
  input wire logic [7:0] side_a_port_lines_oe,
  input wire logic [7:0] side_a_port_lines_out,
  input wire logic [7:0] side_b_port_lines_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  // open drain: only the enable may carry the request
  property p_irq_level;
    disable iff (!rst_b) !side_a_int_req_n_out && !side_b_int_req_n_out;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("request line level not low");
  // mode and latch registers move only on the commit that follows a phase-2 fall
  property p_a_mode_commit;
    disable iff (!rst_b) $changed(side_a_port_lines_oe) |-> !$past(phi2, 3);
  endproperty
  a_a_mode_commit: assert property (p_a_mode_commit)
    else $error("side a mode changed during bus phase");
  property p_a_latch_commit;
    disable iff (!rst_b) $changed(side_a_port_lines_out) |-> !$past(phi2, 3);
  endproperty
  a_a_latch_commit: assert property (p_a_latch_commit)
    else $error("side a latch changed during bus phase");
  property p_b_mode_commit;
    disable iff (!rst_b) $changed(side_b_port_lines_oe) |-> !$past(phi2, 3);
  endproperty
  a_b_mode_commit: assert property (p_b_mode_commit)
    else $error("side b mode changed during bus phase");
  // a request is dropped only by a committed read or control write
  property p_irq_clear;
    disable iff (!rst_b) $fell(side_a_int_req_n_oe) |-> !$past(phi2, 3);
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("side a request dropped during bus phase");
  // the data bus is driven only for a selected read in phase 2
  property p_oe_needs_read;
    disable iff (!rst_b) (!read_not_write) [*8] |-> !host_data_oe;
  endproperty
  a_oe_needs_read: assert property (p_oe_needs_read)
    else $error("bus driven during write");
  property p_oe_needs_phi2;
    disable iff (!rst_b) (!phi2) [*8] |-> !host_data_oe;
  endproperty
  a_oe_needs_phi2: assert property (p_oe_needs_phi2)
    else $error("bus driven outside phase 2");
  property p_oe_needs_sel;
    disable iff (!rst_b) cs_low_n [*8] |-> !host_data_oe;
  endproperty
  a_oe_needs_sel: assert property (p_oe_needs_sel)
    else $error("bus driven while deselected");
  // reset clears everything at once, so no disable here
  property p_reset_clear;
    !rst_b |-> side_a_port_lines_oe == 8'h00 && side_a_port_lines_out == 8'h00
      && side_b_port_lines_oe == 8'h00 && !side_a_int_req_n_oe && !host_data_oe;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared in reset");
  c_irq: cover property ($rose(side_a_int_req_n_oe));
  c_read: cover property ($rose(host_data_oe));
  c_mode: cover property ($changed(side_b_port_lines_oe));
endmodule : dppa_checker

bind dppa_top dppa_checker chk_u (
  .clk(clk), .rst_b(rst_b), .phi2(phi2), .read_not_write(read_not_write),
  .cs_low_n(cs_low_n), .host_data_oe(host_data_oe),
  .side_a_int_req_n_out(side_a_int_req_n_out), .side_b_int_req_n_out(side_b_int_req_n_out),
  .side_a_int_req_n_oe(side_a_int_req_n_oe), .side_a_port_lines_oe(side_a_port_lines_oe),
  .side_a_port_lines_out(side_a_port_lines_out), .side_b_port_lines_oe(side_b_port_lines_oe)
);
`default_nettype wire

// ==== test/dppa_peri_model.sv ====
// peripheral on one port: drives only the lines the adapter leaves as inputs
`default_nettype none
module dppa_peri_model (
  // adapter side
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  // peripheral side
  input wire logic [7:0] ext,
  output logic [7:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // wire level per line: adapter wins where it drives
  assign lines = (drv_out & drv_oe) | (ext & ~drv_oe);
endmodule : dppa_peri_model
`default_nettype wire

// ==== test/dual_parallel_port_adapter_test.sv ====
// self-checking bench for the dual parallel port adapter
`default_nettype none
module dual_parallel_port_adapter_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] mode; logic [7:0] latch; logic [7:0] ext;} dppa_row_t;
  localparam dppa_row_t ROWS [3] = '{{8'hFF, 8'hA5, 8'h00}, {8'h00, 8'h3C, 8'hC3},
    {8'h0F, 8'h55, 8'hAA}};
  // reset starts high so that its first fall is a real edge for the async clear
  logic clk = 0, rst_b = 1, phi2 = 0, rw = 0;
  // chip selects: bit 0 high0, bit 1 high1, bit 2 the active-low one
  logic [2:0] cs = 3'h3;
  logic [1:0] rs = 0, c1 = 0, c2 = 0, ioe, iout, sout, soe;
  logic [7:0] din = 0, q, dout;
  logic doe, qoe;
  logic [7:0] ext [2] = '{8'h00, 8'h00};
  logic [7:0] pout [2], poe [2], pin [2];
  int miscompares = 0, num_checks = 0, cyc = 0;

  dppa_top dut_u (.clk(clk), .rst_b(rst_b), .phi2(phi2), .read_not_write(rw),
    .reg_sel_low(rs[0]), .reg_sel_high(rs[1]), .cs_high0(cs[0]), .cs_high1(cs[1]),
    .cs_low_n(cs[2]), .host_data_in(din), .host_data_out(dout), .host_data_oe(doe),
    .side_a_int_req_n_out(iout[0]), .side_a_int_req_n_oe(ioe[0]),
    .side_b_int_req_n_out(iout[1]), .side_b_int_req_n_oe(ioe[1]),
    .side_a_port_lines_in(pin[0]), .side_a_port_lines_out(pout[0]),
    .side_a_port_lines_oe(poe[0]), .side_a_ctl_in_first(c1[0]),
    .side_a_ctl_line_second_in(soe[0] ? sout[0] : c2[0]),
    .side_a_ctl_line_second_out(sout[0]), .side_a_ctl_line_second_oe(soe[0]),
    .side_b_port_lines_in(pin[1]), .side_b_port_lines_out(pout[1]),
    .side_b_port_lines_oe(poe[1]), .side_b_ctl_in_first(c1[1]),
    .side_b_ctl_line_second_in(soe[1] ? sout[1] : c2[1]),
    .side_b_ctl_line_second_out(sout[1]), .side_b_ctl_line_second_oe(soe[1]));
  dppa_peri_model per_a (.drv_out(pout[0]), .drv_oe(poe[0]), .ext(ext[0]), .lines(pin[0]));
  dppa_peri_model per_b (.drv_out(pout[1]), .drv_oe(poe[1]), .ext(ext[1]), .lines(pin[1]));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one phase-2 pulse; long high and low phases let the synchronisers settle
  task automatic acc(input logic r, input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    phi2 = 1;
    rw = r;
    rs = a;
    din = d;
    repeat (10) @(negedge clk);
    q = dout;
    qoe = doe;
    phi2 = 0;
    repeat (10) @(negedge clk);
    din = ~d;
  endtask : acc
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    acc(1'b1, a, 8'h00);
    chk(q, exp);
    chk({7'h00, qoe}, 8'h01);
  endtask : rd
  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial forever #25 clk = ~clk;
  // hang guard, well above the roughly 1500 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    #1 rst_b = 0;
    repeat (16) @(negedge clk);
    rst_b = 1;
    repeat (8) @(negedge clk);
    for (int s = 0; s < 2; s++) for (int i = 0; i < 3; i++) begin
      acc(1'b0, {s[0], 1'b1}, 8'h00);
      acc(1'b0, {s[0], 1'b0}, ROWS[i].mode);
      rd({s[0], 1'b0}, ROWS[i].mode);
      acc(1'b0, {s[0], 1'b1}, 8'h04);
      acc(1'b0, {s[0], 1'b0}, ROWS[i].latch);
      ext[s] = ROWS[i].ext;
      chk(poe[s], ROWS[i].mode);
      chk(pout[s], ROWS[i].latch);
      rd({s[0], 1'b0}, (ROWS[i].mode & ROWS[i].latch) | (~ROWS[i].mode & ROWS[i].ext));
    end
    // edge flags, request enables and clearing, per side
    for (int s = 0; s < 2; s++) begin
      acc(1'b0, {s[0], 1'b1}, 8'h07);
      c1[s] = 1;
      repeat (10) @(negedge clk);
      rd({s[0], 1'b1}, 8'h87);
      chk({7'h00, ioe[s]}, 8'h01);
      acc(1'b0, {s[0], 1'b1}, 8'h06);
      chk({7'h00, ioe[s]}, 8'h00);
      rd({s[0], 1'b1}, 8'h86);
      acc(1'b1, {s[0], 1'b0}, 8'h00);
      rd({s[0], 1'b1}, 8'h06);
      acc(1'b0, {s[0], 1'b1}, 8'h1C);
      c1[s] = 0;
      c2[s] = 1;
      repeat (10) @(negedge clk);
      rd({s[0], 1'b1}, 8'hDC);
      chk({7'h00, ioe[s]}, 8'h01);
      acc(1'b1, {s[0], 1'b0}, 8'h00);
      rd({s[0], 1'b1}, 8'h1C);
      acc(1'b0, {s[0], 1'b1}, 8'h34);
      chk({6'h00, soe[s], sout[s]}, 8'h03);
      rd({s[0], 1'b1}, 8'h34);
    end
    // each chip select alone deselects: write ignored, bus never driven on a read
    for (int k = 0; k < 3; k++) begin
      cs = 3'h3 ^ (3'h1 << k);
      acc(1'b0, 2'h1, 8'h00);
      acc(1'b1, 2'h0, 8'h00);
      chk({7'h00, qoe}, 8'h00);
      cs = 3'h3;
      rd(2'h1, 8'h34);
    end
    // mid-run reset clears every register
    rst_b = 0;
    @(negedge clk);
    chk(poe[1] | pout[0], 8'h00);
    rst_b = 1;
    repeat (8) @(negedge clk);
    rd(2'h3, 8'h00);
    end_sim();
  end
endmodule : dual_parallel_port_adapter_test
`default_nettype wire
